// File: rtl/sweep_pkg.sv
// constants shared by the sweep stepping and burst control block
// assumes a 40 MHz system clock and a plain strobe register port
package sweep_pkg;
  // register indices on the plain register port
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_START   = 4'h1;
  localparam logic [3:0] ADDR_STEP    = 4'h2;
  localparam logic [3:0] ADDR_NINCR   = 4'h3;
  localparam logic [3:0] ADDR_TINT    = 4'h4;
  localparam logic [3:0] ADDR_TBURST  = 4'h5;
  localparam logic [3:0] ADDR_STATUS  = 4'h6;
  localparam logic [3:0] ADDR_PHASE   = 4'h7;

  // control register fields
  localparam int BIT_MARK_EN    = 2;
  localparam int BIT_MARK_EOS   = 3;
  localparam int BIT_INCR_EXT   = 5;
  localparam int BIT_BURST_EXT  = 6;
  localparam int BIT_CONT       = 7;
  localparam int BIT_SQUARE_EN  = 8;
  localparam int BIT_SINE       = 9;
  localparam int BIT_CONV_ON    = 10;

  // timing register fields
  localparam int BIT_TB_CLOCKS  = 13;
  localparam int BIT_TB_MUL_HI  = 12;
  localparam int BIT_TB_MUL_LO  = 11;
  localparam int TIME_W         = 11;

  localparam int PHASE_W        = 24;
  localparam int NINCR_W        = 12;
  localparam int DAC_W          = 10;
  localparam int PRE_W          = 9;

  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [9:0]  DAC_MIDSCALE = 10'h200;
  localparam logic [2:0]  MARK_PULSE_CYCLES = 3'h4;

  // time-base multipliers less one
  localparam logic [8:0] MUL1_M1   = 9'h000;
  localparam logic [8:0] MUL5_M1   = 9'h004;
  localparam logic [8:0] MUL100_M1 = 9'h063;
  localparam logic [8:0] MUL500_M1 = 9'h1F3;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_BURST = 4'b0010,
    ST_QUIET = 4'b0100,
    ST_DONE  = 4'b1000
  } sweep_state_e;
endpackage

// File: rtl/sine_rom.sv
// quarter-wave sine lookup with registered read data
// assumes the caller holds the phase stable for one cycle per sample
`timescale 1ns/1ps
module sine_rom (
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_en,
  input  wire logic [6:0] i_phase,
  output logic      [9:0] o_amp
);
  logic [4:0] idx;
  logic [8:0] mag;

  function automatic logic [8:0] quarter(input logic [4:0] k);
    case (k)
      5'h00: quarter = 9'h000;  5'h01: quarter = 9'h019;
      5'h02: quarter = 9'h032;  5'h03: quarter = 9'h04B;
      5'h04: quarter = 9'h064;  5'h05: quarter = 9'h07C;
      5'h06: quarter = 9'h094;  5'h07: quarter = 9'h0AC;
      5'h08: quarter = 9'h0C4;  5'h09: quarter = 9'h0DA;
      5'h0A: quarter = 9'h0F1;  5'h0B: quarter = 9'h107;
      5'h0C: quarter = 9'h11C;  5'h0D: quarter = 9'h130;
      5'h0E: quarter = 9'h144;  5'h0F: quarter = 9'h157;
      5'h10: quarter = 9'h169;  5'h11: quarter = 9'h17B;
      5'h12: quarter = 9'h18B;  5'h13: quarter = 9'h19A;
      5'h14: quarter = 9'h1A9;  5'h15: quarter = 9'h1B6;
      5'h16: quarter = 9'h1C3;  5'h17: quarter = 9'h1CE;
      5'h18: quarter = 9'h1D8;  5'h19: quarter = 9'h1E1;
      5'h1A: quarter = 9'h1E9;  5'h1B: quarter = 9'h1F0;
      5'h1C: quarter = 9'h1F5;  5'h1D: quarter = 9'h1FA;
      5'h1E: quarter = 9'h1FD;  default: quarter = 9'h1FF;
    endcase
  endfunction

  // mirror the index in the second and fourth quarter
  assign idx = i_phase[5] ? ~i_phase[4:0] : i_phase[4:0];
  assign mag = quarter(idx);

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_amp <= sweep_pkg::DAC_MIDSCALE;
    end else if (i_en) begin
      o_amp <= i_phase[6] ? (sweep_pkg::DAC_MIDSCALE - {1'b0, mag})
                          : (sweep_pkg::DAC_MIDSCALE + {1'b0, mag});
    end
  end
endmodule

// File: rtl/sweep_step_burst_control.sv
// sweep stepping, burst timing and output selection of a sweep synthesizer
// assumes synchronous pins, one 40 MHz clock and a strobe register port
//
// Functional notes
// - external increment, internal burst: first step pin rise starts the sweep.
// - external increment: each later step pin rise adds the frequency step, until n_incr steps are done.
// - external increment, internal burst: output burst time, then midscale until next step pin rise.
// - external increment, internal burst: time base bits come from burst register.
// - fully external: step pin rise starts; output while pin stays high.
// - fully external: pin low holds output at midscale, the listen period.
// - fully external: each new pin rise steps frequency and bursts again, until n_incr steps are done.
// - fully external: time base select and multiplier bits are ignored.
// - sampled abort rise resets the state machine, output goes midscale.
// - standby high freezes the core clock; accumulator and output hold.
// - standby release resumes the sweep where it stopped.
// - sine select routes phase through the sine lookup.
// - triangle select bypasses lookup; truncated phase gives a 10-bit triangle.
// - square enable drives square pin with inverted converter word msb.
// - marker shows end of sweep or four-clock pulse per increment.
// - marker works only when enabled; a second bit picks its behaviour.
// - sweep begins at start frequency, stepping for the programmed increments.
// - internal increment: interval counts output cycles or scaled clock periods.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module sweep_step_burst_control (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic [3:0]  i_addr,
  input  wire logic [23:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_sweep_step_pin,
  input  wire logic        i_sweep_abort,
  input  wire logic        i_standby,
  output logic      [23:0] o_rdata,
  output logic      [9:0]  o_analog_out_pair,
  output logic             o_converter_on,
  output logic             o_square_out_pin,
  output logic             o_sweep_marker_pin
);
  // ==========================================================
  // registers
  logic [15:0] ctrl;
  logic [23:0] start_freq;
  logic [23:0] freq_step;
  logic [11:0] n_incr;
  logic [13:0] t_int;
  logic [13:0] t_burst;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl       <= sweep_pkg::CTRL_RESET;
      start_freq <= 24'h000000;
      freq_step  <= 24'h000000;
      n_incr     <= 12'h002;
      t_int      <= 14'h0002;
      t_burst    <= 14'h0002;
    end else if (i_ce && i_wr) begin
      if (i_addr == sweep_pkg::ADDR_CTRL) begin
        ctrl <= i_wdata[15:0];
      end else if (i_addr == sweep_pkg::ADDR_START) begin
        start_freq <= i_wdata;
      end else if (i_addr == sweep_pkg::ADDR_STEP) begin
        freq_step <= i_wdata;
      end else if (i_addr == sweep_pkg::ADDR_NINCR) begin
        n_incr <= i_wdata[11:0];
      end else if (i_addr == sweep_pkg::ADDR_TINT) begin
        t_int <= i_wdata[13:0];
      end else if (i_addr == sweep_pkg::ADDR_TBURST) begin
        t_burst <= i_wdata[13:0];
      end
    end
  end

  // ==========================================================
  // mode decode
  logic core_en;
  logic incr_ext;
  logic burst_ext;
  logic cont;
  logic [2:0] tb_bits;

  assign core_en   = i_ce && !i_standby;
  assign incr_ext  = ctrl[sweep_pkg::BIT_INCR_EXT];
  assign burst_ext = ctrl[sweep_pkg::BIT_BURST_EXT];
  assign cont      = ctrl[sweep_pkg::BIT_CONT];
  // time base bits follow the burst register in external increment mode
  assign tb_bits   = incr_ext ? t_burst[13:11] : t_int[13:11];

  function automatic logic [8:0] mul_m1(input logic [1:0] sel);
    case (sel)
      2'h0:    mul_m1 = sweep_pkg::MUL1_M1;
      2'h1:    mul_m1 = sweep_pkg::MUL5_M1;
      2'h2:    mul_m1 = sweep_pkg::MUL100_M1;
      default: mul_m1 = sweep_pkg::MUL500_M1;
    endcase
  endfunction

  // ==========================================================
  // pin synchronisers and edge detection
  logic step_s1, step_s2, step_s3;
  logic abort_s1, abort_s2, abort_s3;
  logic step_rise;
  logic abort_rise;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      step_s1  <= 1'b0;
      step_s2  <= 1'b0;
      step_s3  <= 1'b0;
      abort_s1 <= 1'b0;
      abort_s2 <= 1'b0;
      abort_s3 <= 1'b0;
    end else if (core_en) begin
      step_s1  <= i_sweep_step_pin;
      step_s2  <= step_s1;
      step_s3  <= step_s2;
      abort_s1 <= i_sweep_abort;
      abort_s2 <= abort_s1;
      abort_s3 <= abort_s2;
    end
  end

  assign step_rise  = step_s2 && !step_s3;
  assign abort_rise = abort_s2 && !abort_s3;

  // ==========================================================
  // phase accumulator and frequency word
  logic [23:0] phase;
  logic [23:0] freq;
  logic        msb_prev;
  logic        cycle_tick;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      phase    <= 24'h000000;
      msb_prev <= 1'b0;
    end else if (core_en) begin
      phase    <= phase + freq;
      msb_prev <= phase[sweep_pkg::PHASE_W-1];
    end
  end

  // one tick per completed output cycle
  assign cycle_tick = msb_prev && !phase[sweep_pkg::PHASE_W-1];

  // ==========================================================
  // sweep state machine and timers
  sweep_pkg::sweep_state_e state;
  logic [11:0] incr_cnt;
  logic [8:0]  pre_cnt;
  logic [10:0] tick_cnt;
  logic        base_tick;
  logic        burst_end;
  logic        int_end;
  logic        last_step;
  logic        step_now;
  logic        stepped;

  assign base_tick = tb_bits[2] ? (pre_cnt == mul_m1(tb_bits[1:0])) : cycle_tick;
  assign burst_end = base_tick && (tick_cnt + 11'h001 >= t_burst[10:0]);
  assign int_end   = base_tick && (tick_cnt + 11'h001 >= t_int[10:0]);
  assign last_step = (incr_cnt >= n_incr);
  // an increment happens on a pin rise in external mode, on timeout otherwise
  assign step_now  = incr_ext ? step_rise : int_end;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state    <= sweep_pkg::ST_IDLE;
      freq     <= 24'h000000;
      incr_cnt <= 12'h000;
      stepped  <= 1'b0;
    end else if (core_en) begin
      stepped <= 1'b0;
      if (abort_rise) begin
        state    <= sweep_pkg::ST_IDLE;
        freq     <= 24'h000000;
        incr_cnt <= 12'h000;
      end else begin
        case (state)
          sweep_pkg::ST_IDLE, sweep_pkg::ST_DONE: begin
            if (step_rise) begin
              state    <= sweep_pkg::ST_BURST;
              freq     <= start_freq;
              incr_cnt <= 12'h000;
            end
          end
          sweep_pkg::ST_BURST, sweep_pkg::ST_QUIET: begin
            if (step_now) begin
              if (last_step) begin
                state <= sweep_pkg::ST_DONE;
              end else begin
                state    <= sweep_pkg::ST_BURST;
                freq     <= freq + freq_step;
                incr_cnt <= incr_cnt + 12'h001;
                stepped  <= 1'b1;
              end
            end else if (state == sweep_pkg::ST_BURST && !cont) begin
              if (burst_ext && incr_ext) begin
                if (!step_s2) begin
                  state <= sweep_pkg::ST_QUIET;
                end
              end else if (burst_end) begin
                state <= sweep_pkg::ST_QUIET;
              end
            end
          end
          default: begin
            state <= sweep_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // interval timing restarts at every new frequency
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      pre_cnt  <= 9'h000;
      tick_cnt <= 11'h000;
    end else if (core_en) begin
      if (state == sweep_pkg::ST_IDLE || state == sweep_pkg::ST_DONE || step_now ||
          step_rise || abort_rise) begin
        pre_cnt  <= 9'h000;
        tick_cnt <= 11'h000;
      end else begin
        pre_cnt <= (pre_cnt == mul_m1(tb_bits[1:0])) ? 9'h000 : pre_cnt + 9'h001;
        if (base_tick && tick_cnt != 11'h7FF) begin
          tick_cnt <= tick_cnt + 11'h001;
        end
      end
    end
  end

  // ==========================================================
  // converter word selection
  logic [9:0] sine_amp;
  logic [9:0] tri_amp;
  logic [9:0] next_dac;
  logic       gate_on;

  sine_rom u_sine_rom (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_en      (core_en),
    .i_phase   (phase[23:17]),
    .o_amp     (sine_amp)
  );

  // triangle folds the truncated phase up and back down
  assign tri_amp = phase[23] ? ~phase[22:13] : phase[22:13];
  assign gate_on = (state == sweep_pkg::ST_BURST) ||
                   (cont && state == sweep_pkg::ST_QUIET);

  always_comb begin
    if (!gate_on) begin
      next_dac = sweep_pkg::DAC_MIDSCALE;
    end else if (ctrl[sweep_pkg::BIT_SINE]) begin
      next_dac = sine_amp;
    end else begin
      next_dac = tri_amp;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_analog_out_pair <= sweep_pkg::DAC_MIDSCALE;
      o_square_out_pin  <= 1'b0;
      o_converter_on    <= 1'b0;
    end else if (core_en) begin
      o_analog_out_pair <= next_dac;
      o_square_out_pin  <= ctrl[sweep_pkg::BIT_SQUARE_EN] && !next_dac[9];
      o_converter_on    <= ctrl[sweep_pkg::BIT_CONV_ON];
    end
  end

  // ==========================================================
  // sweep marker
  logic [2:0] mark_cnt;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      mark_cnt           <= 3'h0;
      o_sweep_marker_pin <= 1'b0;
    end else if (core_en) begin
      if (stepped) begin
        mark_cnt <= sweep_pkg::MARK_PULSE_CYCLES - 3'h1;
      end else if (mark_cnt != 3'h0) begin
        mark_cnt <= mark_cnt - 3'h1;
      end
      if (!ctrl[sweep_pkg::BIT_MARK_EN]) begin
        o_sweep_marker_pin <= 1'b0;
      end else if (ctrl[sweep_pkg::BIT_MARK_EOS]) begin
        o_sweep_marker_pin <= (state == sweep_pkg::ST_DONE);
      end else begin
        o_sweep_marker_pin <= stepped || (mark_cnt != 3'h0);
      end
    end
  end

  // ==========================================================
  // register read port
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 24'h000000;
    end else if (i_ce) begin
      if (!i_rd) begin
        o_rdata <= 24'h000000;
      end else if (i_addr == sweep_pkg::ADDR_CTRL) begin
        o_rdata <= {8'h00, ctrl};
      end else if (i_addr == sweep_pkg::ADDR_START) begin
        o_rdata <= start_freq;
      end else if (i_addr == sweep_pkg::ADDR_STEP) begin
        o_rdata <= freq_step;
      end else if (i_addr == sweep_pkg::ADDR_NINCR) begin
        o_rdata <= {12'h000, n_incr};
      end else if (i_addr == sweep_pkg::ADDR_TINT) begin
        o_rdata <= {10'h000, t_int};
      end else if (i_addr == sweep_pkg::ADDR_TBURST) begin
        o_rdata <= {10'h000, t_burst};
      end else if (i_addr == sweep_pkg::ADDR_STATUS) begin
        o_rdata <= {8'h00, state, incr_cnt};
      end else if (i_addr == sweep_pkg::ADDR_PHASE) begin
        o_rdata <= freq;
      end else begin
        o_rdata <= 24'h000000;
      end
    end
  end
endmodule

// File: verification/sweep_step_burst_control_assertions.sv
// checker for the sweep step and burst control ports
// assumes i_ce held high while checked; bound at the foot of this file
`timescale 1ns/1ps
module sweep_ctrl_checker (
  input wire logic        i_clk_sys,
  input wire logic        i_nrst,
  input wire logic        i_ce,
  input wire logic [3:0]  i_addr,
  input wire logic [23:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_sweep_step_pin,
  input wire logic        i_sweep_abort,
  input wire logic        i_standby,
  input wire logic [23:0] o_rdata,
  input wire logic [9:0]  o_analog_out_pair,
  input wire logic        o_converter_on,
  input wire logic        o_square_out_pin,
  input wire logic        o_sweep_marker_pin
);
  logic [15:0] ctrl_q;
  logic [2:0]  calm;
  // ==========
  // shadow control word and cycles since it last changed
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q <= 16'h0000;
      calm   <= 3'h0;
    end else if (i_ce && i_wr && i_addr == sweep_pkg::ADDR_CTRL) begin
      ctrl_q <= i_wdata[15:0];
      calm   <= 3'h0;
    end else if (calm != 3'h7) begin
      calm <= calm + 3'h1;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // ==========
  // properties
  a_square_inv: assert property (o_square_out_pin |-> !o_analog_out_pair[9])
    else $error("square pin high while code msb high");
  a_square_on: assert property ((calm == 3'h7 && ctrl_q[8] && !o_analog_out_pair[9])
    |-> o_square_out_pin) else $error("square pin low while enabled");
  a_conv_copy: assert property (calm == 3'h7 |-> o_converter_on == ctrl_q[10])
    else $error("converter on differs from control");
  a_marker_off: assert property ((calm == 3'h7 && !ctrl_q[2]) |-> !o_sweep_marker_pin)
    else $error("marker active while disabled");
  a_marker_len: assert property (($rose(o_sweep_marker_pin) && !ctrl_q[3])
    |-> o_sweep_marker_pin [*4] ##1 !o_sweep_marker_pin) else $error("marker pulse length");
  a_listen_mid: assert property ((calm == 3'h7 && ctrl_q[7:5] == 3'b011
    && !i_sweep_step_pin && !i_standby) [*8]
    |-> o_analog_out_pair == sweep_pkg::DAC_MIDSCALE) else $error("listen not midscale");
  a_abort_mid: assert property (($rose(i_sweep_abort) && !i_standby) ##1 (!i_standby) [*6]
    |=> o_analog_out_pair == sweep_pkg::DAC_MIDSCALE) else $error("abort not midscale");
  a_standby_hold: assert property (i_standby [*3] |=> $stable(o_analog_out_pair))
    else $error("code moved in standby");
  a_reset_mid: assert property ($rose(i_nrst) |-> o_analog_out_pair == sweep_pkg::DAC_MIDSCALE)
    else $error("code not midscale after reset");
  c_marker: cover property ($rose(o_sweep_marker_pin));
  c_square: cover property ($rose(o_square_out_pin));
  c_standby: cover property ($rose(i_standby));
endmodule
bind sweep_step_burst_control sweep_ctrl_checker u_chk (.i_clk_sys, .i_nrst, .i_ce, .i_addr,
  .i_wdata, .i_wr, .i_rd, .i_sweep_step_pin, .i_sweep_abort, .i_standby, .o_rdata,
  .o_analog_out_pair, .o_converter_on, .o_square_out_pin, .o_sweep_marker_pin);

// File: verification/step_pin_driver.sv
// external controller model driving the step pin
// assumes one-cycle go requests issued just after a rising edge
`timescale 1ns/1ps
module step_pin_driver (
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_go,
  input  wire logic [7:0] i_hi_cycles,
  output logic            o_step
);
  logic [7:0] left;
  // ==========
  // high for the requested count, then low for the listen time
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      left <= 8'h00;
    end else if (i_go) begin
      left <= i_hi_cycles;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign o_step = (left != 8'h00);
endmodule

// File: verification/testbench.sv
// self-checking bench for the sweep step and burst control block
// assumes the step pin driver model and the bound checker
`timescale 1ns/1ps
module testbench;
  logic        i_clk_sys, i_nrst, i_ce, i_wr, i_rd, i_sweep_abort, i_standby, go;
  logic [3:0]  i_addr;
  logic [23:0] i_wdata, o_rdata, rv;
  logic [9:0]  o_analog_out_pair, a0;
  logic        o_converter_on, o_square_out_pin, o_sweep_marker_pin, step;
  logic [7:0]  hi;
  int          n_fail, comparisons, cyc, k, seen, ch;
  sweep_step_burst_control dut (.i_clk_sys, .i_nrst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd,
    .i_sweep_step_pin(step), .i_sweep_abort, .i_standby, .o_rdata, .o_analog_out_pair,
    .o_converter_on, .o_square_out_pin, .o_sweep_marker_pin);
  step_pin_driver u_ctl (.i_clk_sys, .i_nrst, .i_go(go), .i_hi_cycles(hi), .o_step(step));
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  // ==========
  // access tasks
  task automatic complete_run();
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [23:0] e, input string nm);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    rv = o_rdata;
    if (nm != "") chk(nm, e, rv);
  endtask
  task automatic st(input logic [3:0] e);
    rc(sweep_pkg::ADDR_STATUS, 24'h0, "");
    chk("state", {8'h00, e, 12'h000}, rv & 24'hFFF000);
  endtask
  task automatic pulse(input logic [7:0] h);
    @(posedge i_clk_sys);
    go <= 1'b1;
    hi <= h;
    @(posedge i_clk_sys);
    go <= 1'b0;
  endtask
  task automatic mid(input string nm);
    chk(nm, 24'h000200, {14'h0, o_analog_out_pair});
  endtask
  // ==========
  // main sequence
  initial begin
    {i_nrst, i_wr, i_rd, i_sweep_abort, i_standby, go} = 6'h00;
    i_ce = 1'b1;
    i_addr = 4'h0;
    i_wdata = 24'h0;
    hi = 8'h00;
    tick(2);
    i_nrst <= 1'b1;
    rc(sweep_pkg::ADDR_CTRL, 24'h0, "ctrl default");
    rc(sweep_pkg::ADDR_NINCR, 24'h2, "n_incr default");
    rc(sweep_pkg::ADDR_TBURST, 24'h2, "t_burst default");
    wr(sweep_pkg::ADDR_STATUS, 24'hFFFFFF);
    st(4'h1);
    rc(4'hC, 24'h0, "unmapped");
    mid("reset code");
    // external step, internal burst; interval register made huge on purpose
    wr(sweep_pkg::ADDR_START, 24'h100000);
    wr(sweep_pkg::ADDR_STEP, 24'h001000);
    wr(sweep_pkg::ADDR_NINCR, 24'h000002);
    wr(sweep_pkg::ADDR_TINT, 24'h001FFF);
    wr(sweep_pkg::ADDR_TBURST, 24'h002004);
    wr(sweep_pkg::ADDR_CTRL, 24'h000424);
    for (k = 0; k < 4; k++) begin
      pulse(8'h03);
      seen = 0;
      repeat (30) begin
        @(negedge i_clk_sys);
        seen += o_sweep_marker_pin;
      end
      if (k == 1 || k == 2) chk("marker cycles", 24'h4, 24'(seen));
      if (k < 3) begin
        rc(sweep_pkg::ADDR_PHASE, 24'h100000 + 24'(k) * 24'h001000, "freq");
        st(4'h4);
        mid("gap code");
      end
    end
    st(4'h8);
    // fully external, burst register short and ignored, end-of-sweep marker
    wr(sweep_pkg::ADDR_TBURST, 24'h002002);
    wr(sweep_pkg::ADDR_CTRL, 24'h00046C);
    for (k = 0; k < 4; k++) begin
      pulse(8'h50);
      if (k < 3) begin
        tick(40);
        st(4'h2);
        rc(sweep_pkg::ADDR_PHASE, 24'h100000 + 24'(k) * 24'h001000, "ext freq");
        tick(50);
        st(4'h4);
        mid("listen code");
      end
    end
    tick(10);
    st(4'h8);
    chk("marker end", 24'h1, {23'h0, o_sweep_marker_pin});
    // abort in mid burst
    wr(sweep_pkg::ADDR_CTRL, 24'h000460);
    pulse(8'hC8);
    tick(20);
    i_sweep_abort <= 1'b1;
    tick(10);
    i_sweep_abort <= 1'b0;
    st(4'h1);
    mid("abort code");
    tick(200);
    // standby freeze and resume, then abort before reuse
    pulse(8'h3C);
    tick(20);
    i_standby <= 1'b1;
    tick(5);
    @(negedge i_clk_sys);
    a0 = o_analog_out_pair;
    tick(80);
    st(4'h2);
    chk("standby code", {14'h0, a0}, {14'h0, o_analog_out_pair});
    tick(1);
    i_standby <= 1'b0;
    tick(10);
    st(4'h4);
    rc(sweep_pkg::ADDR_PHASE, 24'h100000, "resume freq");
    tick(1);
    i_sweep_abort <= 1'b1;
    tick(8);
    i_sweep_abort <= 1'b0;
    st(4'h1);
    // internal increment and burst, interval of 8 clock periods
    wr(sweep_pkg::ADDR_TINT, 24'h002008);
    wr(sweep_pkg::ADDR_CTRL, 24'h000400);
    pulse(8'h03);
    tick(40);
    st(4'h8);
    rc(sweep_pkg::ADDR_PHASE, 24'h102000, "int freq");
    // sine then triangle, continuous, square output on
    wr(sweep_pkg::ADDR_START, 24'h400000);
    pulse(8'hFF);
    for (k = 0; k < 2; k++) begin
      wr(sweep_pkg::ADDR_CTRL, k == 0 ? 24'h0007A0 : 24'h0005A0);
      tick(10);
      {seen, ch} = 0;
      repeat (8) begin
        @(negedge i_clk_sys);
        if (o_analog_out_pair !== a0) ch++;
        a0 = o_analog_out_pair;
        seen += o_square_out_pin;
      end
      chk("wave moves", 24'h1, {23'h0, ch > 2});
      chk("square toggles", 24'h1, {23'h0, seen > 0 && seen < 8});
      chk("converter on", 24'h1, {23'h0, o_converter_on});
    end
    complete_run();
  end
endmodule
